/* File: logic/tpc_consts.vh */
/*
 * Constants of the timer prescaler and control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the logic files of this block.
 */
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

// ----------------------------------------
// Register offsets (13-bit address space)
// ----------------------------------------
`define TPC_ADDR_W 13
`define TPC_ADDR_COUNT 13'h0008
`define TPC_ADDR_CTRL 13'h0009
`define TPC_ADDR_STAT 13'h000A
`define TPC_ADDR_EVEN 13'h000B

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TPC_CTRL_FLAG 7
`define TPC_CTRL_MASK 6
`define TPC_CTRL_SRC 5
`define TPC_CTRL_EXTEN 4
`define TPC_CTRL_DCLR 3
`define TPC_CTRL_SEL_HI 2
`define TPC_CTRL_SEL_LO 0

// ----------------------------------------
// Event status bits
// ----------------------------------------
`define TPC_EVT_W 3
`define TPC_EVT_ZERO 0
`define TPC_EVT_WRAP 1
`define TPC_EVT_PIN 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPC_CTRL_LOW_RST 6'h37
`define TPC_COUNT_RST 8'hFF
`define TPC_PRE_RST 7'h7F
`define TPC_EVT_RST 3'h0

// ----------------------------------------
// Timing: instruction cycle is the oscillator over five
// ----------------------------------------
`define TPC_MCLK_NS 40
`define TPC_OSC_DIV 5
`define TPC_CYC_NS (`TPC_MCLK_NS * `TPC_OSC_DIV)
`define TPC_CYC_CLKS (`TPC_CYC_NS / `TPC_MCLK_NS)
`define TPC_CYC_HIGH 3'h2

`endif

/* File: logic/tpc_sync.v */
/*
 * Two-flip-flop synchroniser for levels arriving from outside mclk.
 * Assumes the input is a slow level; only the second stage is read.
 */
`timescale 1ns/1ns

module tpc_sync #(
	parameter W = 1
) (
	input wire mclk,
	input wire rst,
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		meta_r <= {W{1'b0}};
		sync_r <= {W{1'b0}};
	end else begin
		meta_r <= d_in;
		sync_r <= meta_r;
	end
end

assign q_out = sync_r;

endmodule

/* File: logic/tpc_prescaler.v */
/*
 * Seven-bit prescaler with a power-of-two tap select.
 * Assumes count_pulse is a one-cycle pulse on each falling edge of the
 * selected count input, on mclk.
 */
`timescale 1ns/1ns
`include "tpc_consts.vh"

module tpc_prescaler #(
	parameter PW = 7
) (
	input wire mclk,
	input wire rst,
	input wire count_pulse,
	input wire divider_clear,
	input wire [2:0] divider_sel,
	output wire tick
);

reg [PW-1:0] pre_r;
wire [PW:0] span;
wire [PW-1:0] tap_mask;

// A tap at divide 2^n fires when the low n bits roll over
assign span = {{PW{1'b0}}, 1'b1} << divider_sel;
assign tap_mask = span[PW-1:0] - {{(PW-1){1'b0}}, 1'b1};
assign tick = count_pulse & ~divider_clear & (&(pre_r | ~tap_mask));

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		pre_r <= `TPC_PRE_RST;
	end else if (divider_clear) begin
		pre_r <= {PW{1'b0}};
	end else if (count_pulse) begin
		pre_r <= pre_r + {{(PW-1){1'b0}}, 1'b1};
	end
end

endmodule

/* File: logic/tpc_top.v */
/*
 * Timer count-source selection, prescaler control, 8-bit down counter,
 * control register and event interrupt logic of a small processor timer.
 * Assumes the CPU core drives the register port on mclk, signals stop and
 * wait on mclk, and that mclk stands for the oscillator.
 */
// Decided for this implementation: the strobed register port.
// Function
// - Both mode bits zero: count internal cycle clock only, pin ignored.
// - Internal clock is the instruction cycle; keeps running during wait.
// - Enable one, source zero: count internal clock ANDed with the pin.
// - Enable zero, source one: no source, prescaler and counter hold.
// - Both one: internal clock suppressed, count from the pin alone.
// - Control register is 8 bits at 0x0009, all readable except bit 3.
// - Source, enable, clear and select bits keep their value over external reset.
// - Request flag sets when counter reaches zero, or when software writes one.
// - Flag clears on external reset, power-on, stop, or software zero.
// - Mask one inhibits; forced to one by resets and stop; writable.
// - Source bit one picks external clock, zero the oscillator over five.
// - Enable bit one lets the pin count, zero blocks it.
// - Writing one to write-only clear bit zeroes prescaler; reads zero.
// - Select codes 000 to 111 divide by 1 through 128.
// - Raise timer request at 0x01 to 0x00 when both masks are clear.
// - Counter decrements continuously, wraps 0x00 to 0xFF, loadable anytime.
// - Prescaler and counter step on the falling edge of the count input.
// - Counter readable anytime without disturbing the count.
`timescale 1ns/1ns
`include "tpc_consts.vh"

module tpc_top #(
	parameter CW = 8,
	parameter PW = 7
) (
	input wire mclk,
	input wire rst,
	input wire ext_reset_pin,
	input wire timer_pin,
	input wire wait_mode,
	input wire stop_exec,
	input wire cpu_irq_mask,
	input wire [`TPC_ADDR_W-1:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output wire [7:0] bus_rdata,
	output wire addr_latch_strobe,
	output wire timer_irq_req,
	output wire evt_irq
);

// ----------------------------------------
// Declarations
// ----------------------------------------
localparam integer CYC_LEN = `TPC_CYC_CLKS;
localparam [2:0] CYC_LAST = CYC_LEN[2:0] - 3'h1;
localparam [2:0] CYC_HIGH = `TPC_CYC_HIGH;
localparam [5:0] CTRL_LOW_RST = `TPC_CTRL_LOW_RST;

reg [2:0] phase_r;
reg [2:0] phase_nxt;
reg icyc_r;
reg als_r;
reg cin_d_r;
reg cin;
reg pin_d_r;
reg tick_request_flag_r;
reg tick_irq_mask_r;
reg count_source_sel_r;
reg ext_pin_enable_r;
reg [2:0] divider_sel_r;
reg [CW-1:0] count_r;
reg [CW-1:0] count_nxt;
reg [`TPC_EVT_W-1:0] evt_stat_r;
reg [`TPC_EVT_W-1:0] evt_stat_nxt;
reg [`TPC_EVT_W-1:0] evt_en_r;
reg [7:0] rdata_r;
reg [7:0] rdata_nxt;
reg treq_r;
reg evt_irq_r;

wire pin_s;
wire ext_rst_s;
wire cnt_fall;
wire pre_tick;
wire wr_ctrl;
wire wr_count;
wire wr_stat;
wire wr_even;
wire divider_clear;
wire zero_evt;
wire wrap_evt;
wire pin_rise;
wire [`TPC_EVT_W-1:0] evt_now;
wire flag_clr;

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
tpc_sync #(
	.W(2)
) u_sync (
	.mclk(mclk),
	.rst(rst),
	.d_in({ext_reset_pin, timer_pin}),
	.q_out({ext_rst_s, pin_s})
);

// ----------------------------------------
// Instruction cycle clock
// ----------------------------------------
always @* begin
	if (phase_r == CYC_LAST) begin
		phase_nxt = 3'h0;
	end else begin
		phase_nxt = phase_r + 3'h1;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		phase_r <= 3'h0;
		icyc_r <= 1'b0;
		als_r <= 1'b0;
	end else begin
		phase_r <= phase_nxt;
		// Timer clock runs through wait; only the strobe pin drops
		icyc_r <= (phase_nxt < CYC_HIGH);
		als_r <= (phase_nxt < CYC_HIGH) & ~wait_mode;
	end
end

assign addr_latch_strobe = als_r;

// ----------------------------------------
// Count source selection
// ----------------------------------------
always @* begin
	case ({count_source_sel_r, ext_pin_enable_r})
	2'b00: begin
		cin = icyc_r;
	end
	2'b01: begin
		cin = icyc_r & pin_s;
	end
	2'b10: begin
		cin = 1'b0;
	end
	2'b11: begin
		cin = pin_s;
	end
	default: begin
		cin = 1'b0;
	end
	endcase
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		cin_d_r <= 1'b0;
		pin_d_r <= 1'b0;
	end else begin
		cin_d_r <= cin;
		pin_d_r <= pin_s;
	end
end

// Mode changes may fake one edge, as a gated clock would
assign cnt_fall = cin_d_r & ~cin;
assign pin_rise = pin_s & ~pin_d_r;

// ----------------------------------------
// Register port decode
// ----------------------------------------
assign wr_ctrl = bus_wr & (bus_addr == `TPC_ADDR_CTRL);
assign wr_count = bus_wr & (bus_addr == `TPC_ADDR_COUNT);
assign wr_stat = bus_wr & (bus_addr == `TPC_ADDR_STAT);
assign wr_even = bus_wr & (bus_addr == `TPC_ADDR_EVEN);
assign divider_clear = wr_ctrl & bus_wdata[`TPC_CTRL_DCLR];

// ----------------------------------------
// Prescaler
// ----------------------------------------
tpc_prescaler #(
	.PW(PW)
) u_pre (
	.mclk(mclk),
	.rst(rst),
	.count_pulse(cnt_fall),
	.divider_clear(divider_clear),
	.divider_sel(divider_sel_r),
	.tick(pre_tick)
);

// ----------------------------------------
// Down counter
// ----------------------------------------
assign zero_evt = pre_tick & ~wr_count & (count_r == {{(CW-1){1'b0}}, 1'b1});
assign wrap_evt = pre_tick & ~wr_count & (count_r == {CW{1'b0}});

always @* begin
	if (ext_rst_s) begin
		count_nxt = `TPC_COUNT_RST;
	end else if (wr_count) begin
		// Load wins over a tick in the same cycle
		count_nxt = bus_wdata[CW-1:0];
	end else if (pre_tick) begin
		count_nxt = count_r - {{(CW-1){1'b0}}, 1'b1};
	end else begin
		count_nxt = count_r;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		count_r <= `TPC_COUNT_RST;
	end else begin
		count_r <= count_nxt;
	end
end

// ----------------------------------------
// Control register
// ----------------------------------------
// Low fields only see power-on reset, never the external reset
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		count_source_sel_r <= CTRL_LOW_RST[`TPC_CTRL_SRC];
		ext_pin_enable_r <= CTRL_LOW_RST[`TPC_CTRL_EXTEN];
		divider_sel_r <= CTRL_LOW_RST[`TPC_CTRL_SEL_HI:`TPC_CTRL_SEL_LO];
	end else if (wr_ctrl) begin
		count_source_sel_r <= bus_wdata[`TPC_CTRL_SRC];
		ext_pin_enable_r <= bus_wdata[`TPC_CTRL_EXTEN];
		divider_sel_r <= bus_wdata[`TPC_CTRL_SEL_HI:`TPC_CTRL_SEL_LO];
	end
end

assign flag_clr = ext_rst_s | stop_exec;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		tick_request_flag_r <= 1'b0;
		tick_irq_mask_r <= 1'b1;
	end else begin
		if (flag_clr) begin
			tick_request_flag_r <= 1'b0;
		end else if (zero_evt) begin
			// Hardware set wins over a software clear
			tick_request_flag_r <= 1'b1;
		end else if (wr_ctrl) begin
			tick_request_flag_r <= bus_wdata[`TPC_CTRL_FLAG];
		end
		if (flag_clr) begin
			tick_irq_mask_r <= 1'b1;
		end else if (wr_ctrl) begin
			tick_irq_mask_r <= bus_wdata[`TPC_CTRL_MASK];
		end
	end
end

// ----------------------------------------
// Event status and enables
// ----------------------------------------
assign evt_now = {pin_rise, wrap_evt, zero_evt};

always @* begin
	evt_stat_nxt = evt_stat_r;
	if (wr_stat) begin
		evt_stat_nxt = evt_stat_nxt & ~bus_wdata[`TPC_EVT_W-1:0];
	end
	// Set after clear so an event in the clearing cycle survives
	evt_stat_nxt = evt_stat_nxt | evt_now;
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		evt_stat_r <= `TPC_EVT_RST;
		evt_en_r <= `TPC_EVT_RST;
	end else begin
		evt_stat_r <= evt_stat_nxt;
		if (wr_even) begin
			evt_en_r <= bus_wdata[`TPC_EVT_W-1:0];
		end
	end
end

// ----------------------------------------
// Interrupt outputs
// ----------------------------------------
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		treq_r <= 1'b0;
		evt_irq_r <= 1'b0;
	end else begin
		treq_r <= tick_request_flag_r & ~tick_irq_mask_r & ~cpu_irq_mask;
		evt_irq_r <= |(evt_stat_r & evt_en_r);
	end
end

assign timer_irq_req = treq_r;
assign evt_irq = evt_irq_r;

// ----------------------------------------
// Read data
// ----------------------------------------
always @* begin
	case (bus_addr)
	`TPC_ADDR_COUNT: begin
		rdata_nxt = count_r;
	end
	`TPC_ADDR_CTRL: begin
		rdata_nxt = {tick_request_flag_r, tick_irq_mask_r, count_source_sel_r,
			ext_pin_enable_r, 1'b0, divider_sel_r};
	end
	`TPC_ADDR_STAT: begin
		rdata_nxt = {{(8-`TPC_EVT_W){1'b0}}, evt_stat_r};
	end
	`TPC_ADDR_EVEN: begin
		rdata_nxt = {{(8-`TPC_EVT_W){1'b0}}, evt_en_r};
	end
	default: begin
		rdata_nxt = 8'h00;
	end
	endcase
end

// Data held only in the cycle after the read strobe
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		rdata_r <= 8'h00;
	end else if (bus_rd) begin
		rdata_r <= rdata_nxt;
	end else begin
		rdata_r <= 8'h00;
	end
end

assign bus_rdata = rdata_r;

endmodule

/* File: sim/tpc_top_properties.sv */
/* Port checker of the timer block.
   Assumes binding to tpc_top; one clock mclk, async reset rst. */
`timescale 1ns/1ns
module tpc_top_chk (
	input logic mclk,
	input logic rst,
	input logic ext_reset_pin,
	input logic timer_pin,
	input logic wait_mode,
	input logic stop_exec,
	input logic cpu_irq_mask,
	input logic [12:0] bus_addr,
	input logic [7:0] bus_wdata,
	input logic bus_wr,
	input logic bus_rd,
	input logic [7:0] bus_rdata,
	input logic addr_latch_strobe,
	input logic timer_irq_req,
	input logic evt_irq
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_hi_pair;
		$rose(addr_latch_strobe) ##1 addr_latch_strobe;
	endsequence
	sequence s_lo_gap;
		!addr_latch_strobe [*3] ##1 addr_latch_strobe;
	endsequence
	sequence s_flag_set;
		bus_wr && bus_addr == 13'h0009 && bus_wdata[7:6] == 2'b10 && !stop_exec
		##1 !cpu_irq_mask && !stop_exec && !bus_wr && !ext_reset_pin;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RD_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data outside its slot");
	AST_CTRL_B3: assert property ($past(bus_rd) && $past(bus_addr) == 13'h0009 |-> !bus_rdata[3])
		else $error("clear bit read back as one");
	AST_CPU_MASK: assert property (cpu_irq_mask |=> !timer_irq_req)
		else $error("timer request while cpu masked");
	AST_STOP: assert property (stop_exec |-> ##2 !timer_irq_req)
		else $error("timer request after stop");
	AST_WAIT_LOW: assert property (wait_mode && $past(wait_mode) |-> !addr_latch_strobe)
		else $error("strobe high in wait");
	AST_STROBE_RATE: assert property (disable iff (rst || wait_mode) s_hi_pair |=> s_lo_gap)
		else $error("cycle strobe not two high three low");
	AST_XRST: assert property (ext_reset_pin [*4] |-> ##2 !timer_irq_req)
		else $error("timer request through external reset");
	AST_FLAG_SET: assert property (s_flag_set |-> ##1 timer_irq_req)
		else $error("software flag set gave no request");
endmodule

bind tpc_top tpc_top_chk i_tpc_top_chk (.mclk(mclk), .rst(rst), .ext_reset_pin(ext_reset_pin),
	.timer_pin(timer_pin), .wait_mode(wait_mode), .stop_exec(stop_exec),
	.cpu_irq_mask(cpu_irq_mask), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .addr_latch_strobe(addr_latch_strobe),
	.timer_irq_req(timer_irq_req), .evt_irq(evt_irq));

/* File: sim/tpc_pin_model.sv */
/* External timer pin source: pulses three high, four low, or a held level.
   Assumes mclk from the bench. */
`timescale 1ns/1ns
module tpc_pin_model (
	input logic mclk,
	input logic run,
	input logic lvl,
	output logic pin
);
	logic [2:0] ph_r = 3'h0;
	// Pulses two cycles or wider, else the synchroniser may miss them
	always @(posedge mclk) begin
		ph_r <= (ph_r == 3'h6) ? 3'h0 : ph_r + 3'h1;
		pin <= run ? (ph_r < 3'h3) : lvl;
	end
endmodule

/* File: sim/tpc_top_tb.sv */
/* Self-checking bench of the timer block.
   Assumes tpc_top, the pin model and a 40 ns mclk. */
`timescale 1ns/1ns
module tpc_top_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic xrst = 1'b0;
	logic wt = 1'b0;
	logic stp = 1'b0;
	logic cim = 1'b1;
	logic [12:0] ad = 13'h0000;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic lvl = 1'b0;
	logic pin;
	logic [7:0] rdat;
	logic als;
	logic tirq;
	logic eirq;
	logic [7:0] v;
	logic [7:0] a;
	logic [7:0] mc [5] = '{8'h40, 8'h60, 8'h70, 8'h50, 8'h50};
	int per [5] = '{5, 5, 7, 5, 5};
	int tk [5] = '{1, 0, 1, 1, 0};
	logic [4:0] rn = 5'h07;
	logic [4:0] lv = 5'h08;
	integer seed = 32'h8E4B5BF5;
	integer bad_count = 0;
	integer comparisons = 0;
	integer i;
	integer d;
	integer r;
	always #20 mclk = ~mclk;
	tpc_top i_tpc_top (.mclk(mclk), .rst(rst), .ext_reset_pin(xrst), .timer_pin(pin),
		.wait_mode(wt), .stop_exec(stp), .cpu_irq_mask(cim), .bus_addr(ad), .bus_wdata(wd),
		.bus_wr(wr), .bus_rd(rd), .bus_rdata(rdat), .addr_latch_strobe(als),
		.timer_irq_req(tirq), .evt_irq(eirq));
	tpc_pin_model i_tpc_pin_model (.mclk(mclk), .run(run), .lvl(lvl), .pin(pin));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_b(input logic [12:0] ai, input logic [7:0] di);
		ad <= ai;
		wd <= di;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd_b(input logic [12:0] ai, output logic [7:0] q);
		ad <= ai;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 q = rdat;
		@(posedge mclk);
	endtask
	// Registered levels are looked at mid-cycle, clear of the edge that launches them
	task automatic chk_lvl(input string nm, input logic e, input logic sel_evt);
		@(negedge mclk);
		chk(nm, {7'h00, e}, {7'h00, sel_evt ? eirq : tirq});
		@(posedge mclk);
	endtask
	// Two reads spaced cyc apart must see exactly n steps down
	task automatic tick_chk(input string nm, input integer cyc, input integer n);
		rd_b(13'h0008, a);
		repeat (cyc - 2) @(posedge mclk);
		rd_b(13'h0008, v);
		chk(nm, a - n[7:0], v);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		summarize();
	end
	// ----------------------------------------
	// Sequence of tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_b(13'h0009, v);
		chk("ctrl_rst", 8'h77, v);
		rd_b(13'h0008, v);
		chk("count_rst", 8'hFF, v);
		rd_b(13'h0100, v);
		chk("unmapped", 8'h00, v);
		$display("test reset done");
		for (i = 0; i < 5; i++) begin
			run <= rn[i];
			lvl <= lv[i];
			r = $random(seed);
			d = 1 + {$random(seed)} % 3;
			wr_b(13'h0009, mc[i]);
			wr_b(13'h0008, r[7:0]);
			repeat (12) @(posedge mclk);
			tick_chk("mode", per[i] * d, tk[i] * d);
		end
		run <= 1'b0;
		$display("test modes done");
		for (i = 0; i < 8; i++) begin
			wr_b(13'h0009, 8'h48 | i[7:0]);
			wr_b(13'h0008, 8'h02);
			repeat (4) @(posedge mclk);
			tick_chk("divide", 5 * (1 << i) * 2, 2);
			rd_b(13'h0009, v);
			chk("ctrl_b3", 8'h40 | i[7:0], v & 8'h7F);
		end
		$display("test divide done");
		wt <= 1'b1;
		wr_b(13'h0009, 8'h40);
		tick_chk("wait", 15, 3);
		wt <= 1'b0;
		$display("test wait done");
		cim <= 1'b0;
		wr_b(13'h0009, 8'h00);
		wr_b(13'h0008, 8'h02);
		repeat (20) @(posedge mclk);
		chk_lvl("tirq_zero", 1'b1, 1'b0);
		rd_b(13'h0009, v);
		chk("flag", 8'h80, v & 8'h80);
		wr_b(13'h000B, 8'h01);
		chk_lvl("evt_on", 1'b1, 1'b1);
		wr_b(13'h000B, 8'h00);
		chk_lvl("evt_masked", 1'b0, 1'b1);
		wr_b(13'h000B, 8'h01);
		wr_b(13'h000A, 8'h07);
		chk_lvl("evt_clr", 1'b0, 1'b1);
		rd_b(13'h000A, v);
		chk("stat_clr", 8'h00, v);
		wr_b(13'h0009, 8'h00);
		chk_lvl("tirq_sw0", 1'b0, 1'b0);
		wr_b(13'h0009, 8'h80);
		chk_lvl("tirq_sw1", 1'b1, 1'b0);
		stp <= 1'b1;
		@(posedge mclk);
		stp <= 1'b0;
		rd_b(13'h0009, v);
		chk("ctrl_stop", 8'h40, v);
		$display("test interrupt done");
		wr_b(13'h0009, 8'hA5);
		xrst <= 1'b1;
		repeat (6) @(posedge mclk);
		xrst <= 1'b0;
		repeat (4) @(posedge mclk);
		rd_b(13'h0009, v);
		chk("ctrl_xrst", 8'h65, v);
		rd_b(13'h0008, v);
		chk("count_xrst", 8'hFF, v);
		$display("test external reset done");
		summarize();
	end
endmodule
